/* verification/abo_base_offset_checker.sv */
// Port assertions for the base-offset block
`timescale 1ns/1ps
`default_nettype none
`include "abo_defs.svh"
module abo_base_offset_checker (
    // Clock, reset, register port
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // Run handshake
    input wire logic        dp_done_in,
    input wire logic        dp_start_out,
    input wire logic        busy_out,
    // Address path
    input wire logic [31:0] dp_rd_addr_in,
    input wire logic        dp_rd_valid_in,
    input wire logic [31:0] dp_wr_addr_in,
    input wire logic        dp_wr_valid_in,
    input wire logic [31:0] mem_rd_addr_out,
    input wire logic        mem_rd_valid_out,
    input wire logic [31:0] mem_wr_addr_out,
    input wire logic        mem_wr_valid_out
);
    // ==========================================
    // Helper state
    logic [31:0] rd_rel_q;  // Relative read address of last cycle
    logic [31:0] wr_rel_q;  // Relative write address of last cycle
    logic [31:0] rd_off_q;  // Read offset seen last cycle
    logic [31:0] wr_off_q;  // Write offset seen last cycle
    logic        ran_q;     // A start has been issued since reset
    logic        steady;    // Busy and not in the start-pulse cycle
    assign steady = busy_out && !dp_start_out;
    // Track offsets so a base change shows as a jump
    always_ff @(posedge clk_in) begin
        rd_rel_q <= dp_rd_addr_in;
        wr_rel_q <= dp_wr_addr_in;
        rd_off_q <= mem_rd_addr_out - rd_rel_q;
        wr_off_q <= mem_wr_addr_out - wr_rel_q;
        ran_q    <= rst_n_in && (ran_q || dp_start_out);
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================
    // Start sequence
    sequence s_start_req;
        reg_wr_in && reg_addr_in == `ABO_REG_CTRL && reg_wdata_in[0] && !busy_out;
    endsequence
    sequence s_load_run;
        busy_out && !dp_start_out ##1 busy_out && dp_start_out;
    endsequence
    a_start_order: assert property (s_start_req |=> s_load_run)
        else $error("start did not load then run");
    a_start_pulse: assert property (dp_start_out |=> !dp_start_out)
        else $error("start pulse too long");
    a_done_idle: assert property (busy_out && $past(busy_out) && dp_done_in |=> !busy_out)
        else $error("busy stayed after done");
    a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data without read");
    // ==========================================
    // Address path
    a_rd_follow: assert property (dp_rd_valid_in |=> mem_rd_valid_out)
        else $error("read address dropped");
    a_rd_quiet: assert property (!dp_rd_valid_in |=> !mem_rd_valid_out)
        else $error("stray read address");
    a_wr_follow: assert property (dp_wr_valid_in |=> mem_wr_valid_out)
        else $error("write address dropped");
    a_zero_base: assert property (!ran_q && mem_rd_valid_out |-> mem_rd_addr_out == rd_rel_q)
        else $error("nonzero base before first run");
    a_rd_held: assert property (steady && $past(steady) && mem_rd_valid_out
        |-> mem_rd_addr_out - rd_rel_q == rd_off_q)
        else $error("read base moved in a run");
    a_wr_held: assert property (steady && $past(steady) && mem_wr_valid_out
        |-> mem_wr_addr_out - wr_rel_q == wr_off_q)
        else $error("write base moved in a run");
endmodule : abo_base_offset_checker
bind abo_base_offset abo_base_offset_checker chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dp_done_in(dp_done_in),
    .dp_start_out(dp_start_out), .busy_out(busy_out), .dp_rd_addr_in(dp_rd_addr_in),
    .dp_rd_valid_in(dp_rd_valid_in), .dp_wr_addr_in(dp_wr_addr_in),
    .dp_wr_valid_in(dp_wr_valid_in), .mem_rd_addr_out(mem_rd_addr_out),
    .mem_rd_valid_out(mem_rd_valid_out), .mem_wr_addr_out(mem_wr_addr_out),
    .mem_wr_valid_out(mem_wr_valid_out));
`default_nettype wire

/* verification/abo_mem_model.sv */
// Memory-side model: counts accepted read and write addresses
`timescale 1ns/1ps
`default_nettype none
module abo_mem_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Absolute addresses from the block
    input  wire logic [31:0] mem_rd_addr_in,
    input  wire logic        mem_rd_valid_in,
    input  wire logic [31:0] mem_wr_addr_in,
    input  wire logic        mem_wr_valid_in,
    // Observed traffic
    output logic      [31:0] rd_count_out,
    output logic      [31:0] wr_count_out
);
    // ==========================================
    // Traffic counters
    // Each accepted address counts once; memory never stalls
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_count_out <= 32'h0;
            wr_count_out <= 32'h0;
        end else begin
            rd_count_out <= rd_count_out + {31'h0, mem_rd_valid_in};
            wr_count_out <= wr_count_out + {31'h0, mem_wr_valid_in};
        end
    end
endmodule : abo_mem_model
`default_nettype wire

/* verification/axi_master_base_offset_tb_top.sv */
// Random testbench for the base-offset block, read in register mode, write in port mode
`timescale 1ns/1ps
`default_nettype none
`include "abo_defs.svh"
module axi_master_base_offset_tb_top;
    import abo_pkg::*;
    // ==========================================
    // Signals
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, dp_done_in = 1'b0;
    logic dp_rd_valid_in = 1'b0, dp_wr_valid_in = 1'b0, dp_start_out, busy_out;
    logic mem_rd_valid_out, mem_wr_valid_out;
    logic [7:0]  reg_addr_in = 8'h0;
    logic [31:0] reg_wdata_in = 32'h0, rd_base_port_in = 32'h0, wr_base_port_in = 32'h0;
    logic [31:0] dp_rd_addr_in = 32'h0, dp_wr_addr_in = 32'h0, reg_rdata_out;
    logic [31:0] mem_rd_addr_out, mem_wr_addr_out, rd_count, wr_count;
    logic [31:0] base_rd, base_wr, nrd, nwr;  // Expected held bases
    logic [31:0] fx_rdata, fx_rd_addr, fx_wr_addr, fx_rd;  // Fixed-mode instance view
    localparam logic [31:0] FIX_BASE = 32'h00001000;        // Its integration read base
    int miscompares = 0, check_count = 0, seed = 19936, n_rd = 0, n_wr = 0, k;
    always #5 clk_in = ~clk_in;
    abo_base_offset #(.RD_MODE(ABO_MODE_REG), .WR_MODE(ABO_MODE_PORT)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .rd_base_port_in(rd_base_port_in),
        .wr_base_port_in(wr_base_port_in), .dp_done_in(dp_done_in),
        .dp_start_out(dp_start_out), .busy_out(busy_out), .dp_rd_addr_in(dp_rd_addr_in),
        .dp_rd_valid_in(dp_rd_valid_in), .dp_wr_addr_in(dp_wr_addr_in),
        .dp_wr_valid_in(dp_wr_valid_in), .mem_rd_addr_out(mem_rd_addr_out),
        .mem_rd_valid_out(mem_rd_valid_out), .mem_wr_addr_out(mem_wr_addr_out),
        .mem_wr_valid_out(mem_wr_valid_out));
    abo_mem_model mem_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .mem_rd_addr_in(mem_rd_addr_out),
        .mem_rd_valid_in(mem_rd_valid_out), .mem_wr_addr_in(mem_wr_addr_out),
        .mem_wr_valid_in(mem_wr_valid_out), .rd_count_out(rd_count), .wr_count_out(wr_count));
    // Second instance: fixed read master, write master left to the global port mode
    abo_base_offset #(.RD_MODE(ABO_MODE_FIXED), .WR_MODE(ABO_MODE_NONE),
        .GLOBAL_MODE(ABO_MODE_PORT), .HAS_CTRL(1'b0), .RD_FIXED_BASE(FIX_BASE)) fix_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(fx_rdata), .rd_base_port_in(rd_base_port_in),
        .wr_base_port_in(wr_base_port_in), .dp_done_in(dp_done_in),
        .dp_start_out(), .busy_out(), .dp_rd_addr_in(dp_rd_addr_in),
        .dp_rd_valid_in(dp_rd_valid_in), .dp_wr_addr_in(dp_wr_addr_in),
        .dp_wr_valid_in(dp_wr_valid_in), .mem_rd_addr_out(fx_rd_addr),
        .mem_rd_valid_out(), .mem_wr_addr_out(fx_wr_addr), .mem_wr_valid_out());
    // ==========================================
    // Checking and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    function automatic logic [31:0] abs_addr(input logic [31:0] base, input logic [31:0] rel);
        return base + rel;
    endfunction : abs_addr
    task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_in);
        reg_addr_in  <= addr;
        reg_wdata_in <= data;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] addr, input logic [31:0] want);
        @(posedge clk_in);
        reg_addr_in <= addr;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1 check(reg_rdata_out, want);
    endtask : reg_read
    // Back-to-back random traffic; each result checked one cycle later
    task automatic traffic(input int cycles);
        logic [31:0] ra, wa, pra, pwa;
        logic        rv, wv, prv, pwv;
        prv = 1'b0;
        pwv = 1'b0;
        for (int i = 0; i <= cycles; i++) begin
            ra = $random(seed);
            wa = $random(seed);
            rv = (i < cycles) && ra[0];
            wv = (i < cycles) && wa[1];
            @(posedge clk_in);
            dp_rd_addr_in  <= ra;
            dp_rd_valid_in <= rv;
            dp_wr_addr_in  <= wa;
            dp_wr_valid_in <= wv;
            #1 check({31'h0, mem_rd_valid_out}, {31'h0, prv});
            check({31'h0, mem_wr_valid_out}, {31'h0, pwv});
            if (prv) check(mem_rd_addr_out, abs_addr(base_rd, pra));
            if (pwv) check(mem_wr_addr_out, abs_addr(base_wr, pwa));
            if (prv) check(fx_rd_addr, abs_addr(fx_rd, pra));
            if (pwv) check(fx_wr_addr, abs_addr(base_wr, pwa));
            n_rd += prv;
            n_wr += pwv;
            {prv, pra, pwv, pwa} = {rv, ra, wv, wa};
        end
    endtask : traffic
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        base_rd = 32'h0;
        base_wr = 32'h0;
        fx_rd = 32'h0;
        traffic(8);
        reg_read(8'h3C, 32'h0);
        for (int j = 0; j < 3; j++) begin
            nrd = (j == 2) ? 32'hFFFFFFF0 : $random(seed);
            nwr = $random(seed);
            @(posedge clk_in);
            wr_base_port_in <= nwr;
            rd_base_port_in <= nrd;
            reg_write(`ABO_REG_BASE_RD, nrd);
            reg_read(`ABO_REG_BASE_RD, nrd);
            check(fx_rdata, 32'h0);
            reg_write(`ABO_REG_CTRL, 32'h1);
            for (k = 0; k < 8 && dp_start_out !== 1'b1; k++) @(posedge clk_in) #1;
            check(k, 1);
            if (k == 8) print_verdict();
            {base_rd, base_wr} = {nrd, nwr};
            fx_rd = FIX_BASE;
            traffic(12);
            @(posedge clk_in);
            wr_base_port_in <= ~nwr;
            rd_base_port_in <= ~nrd;
            reg_write(`ABO_REG_BASE_RD, ~nrd);
            traffic(12);
            @(posedge clk_in);
            dp_done_in <= 1'b1;
            @(posedge clk_in);
            dp_done_in <= 1'b0;
            #1 check({31'h0, busy_out}, 32'h0);
            reg_read(`ABO_REG_ACTIVE_RD, nrd);
            check(fx_rdata, FIX_BASE);
            reg_read(`ABO_REG_ACTIVE_WR, nwr);
            reg_read(`ABO_REG_STATUS, 32'h2);
        end
        @(posedge clk_in) #1;
        check(rd_count, 32'(n_rd));
        check(wr_count, 32'(n_wr));
        print_verdict();
    end
endmodule : axi_master_base_offset_tb_top
`default_nettype wire

/* verilog/abo_base_offset.sv */
// Base-offset adder and control registers for two memory master channels
`timescale 1ns/1ps
`default_nettype none
`include "abo_defs.svh"

// Sits between the datapath and the memory interconnect. The datapath
// issues addresses relative to zero; this block adds the base chosen by
// the mode parameters and hands absolute addresses to the memory side.
// Each master resolves its own mode at elaboration, so a fixed-base
// master carries no run-time base path at all.
// The base is captured once per run in the load state, so a host or
// port change in mid-run cannot split one run across two regions.
// Users must set port or register bases before writing the start bit.
// Memory never stalls here; back-pressure is handled downstream.
module abo_base_offset
    import abo_pkg::*;
#(
    parameter abo_mode_e RD_MODE     = ABO_MODE_NONE,  // Read master mode
    parameter abo_mode_e WR_MODE     = ABO_MODE_NONE,  // Write master mode
    parameter abo_mode_e GLOBAL_MODE = ABO_MODE_FIXED, // Mode when none set
    parameter bit        HAS_CTRL    = 1'b1,           // Control slave present
    parameter logic [31:0] RD_FIXED_BASE = `ABO_FIXED_BASE, // Integration base
    parameter logic [31:0] WR_FIXED_BASE = `ABO_FIXED_BASE  // Integration base
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Control register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Run-time base ports, port mode
    input  wire logic [31:0] rd_base_port_in,
    input  wire logic [31:0] wr_base_port_in,
    // Datapath handshake
    input  wire logic        dp_done_in,
    output logic             dp_start_out,
    output logic             busy_out,
    // Datapath relative addresses
    input  wire logic [31:0] dp_rd_addr_in,
    input  wire logic        dp_rd_valid_in,
    input  wire logic [31:0] dp_wr_addr_in,
    input  wire logic        dp_wr_valid_in,
    // Memory-side absolute addresses
    output logic      [31:0] mem_rd_addr_out,
    output logic             mem_rd_valid_out,
    output logic      [31:0] mem_wr_addr_out,
    output logic             mem_wr_valid_out
);

    // ======================================================
    // Mode resolution
    // An unset mode takes the global one, except that a control slave
    // forces register mode. Register mode without a control slave has
    // nowhere to hold its base, so it degrades to fixed.
    // Picks the effective mode of one master
    function automatic abo_mode_e resolve_mode(input abo_mode_e m);
        abo_mode_e r;
        r = m;
        if (m == ABO_MODE_NONE) begin
            r = HAS_CTRL ? ABO_MODE_REG : GLOBAL_MODE;
        end
        if (r == ABO_MODE_NONE) begin
            r = ABO_MODE_FIXED;
        end
        if (r == ABO_MODE_REG && !HAS_CTRL) begin
            r = ABO_MODE_FIXED;
        end
        return r;
    endfunction : resolve_mode

    localparam abo_mode_e RD_EFF = resolve_mode(RD_MODE);
    localparam abo_mode_e WR_EFF = resolve_mode(WR_MODE);

    // Picks the base source for a master
    // Fixed is the fallback so an odd mode code still gives a sane base
    function automatic logic [31:0] pick_base(input abo_mode_e m,
                                              input logic [31:0] fixed_b,
                                              input logic [31:0] port_b,
                                              input logic [31:0] reg_b);
        logic [31:0] b;
        b = fixed_b;
        if (m == ABO_MODE_PORT) begin
            b = port_b;
        end else if (m == ABO_MODE_REG) begin
            b = reg_b;
        end
        return b;
    endfunction : pick_base

    // Adds base to a relative address
    // Carry out of bit 31 is dropped on purpose: addresses wrap
    function automatic logic [31:0] add_base(input logic [31:0] base,
                                             input logic [31:0] rel);
        return base + rel;
    endfunction : add_base

    // ======================================================
    // Port synchronisers
    // The base ports may come from a pin or another clock, so every bit
    // passes two flops before use. A word caught mid-change is harmless
    // as long as the port is steady two cycles before a start, because
    // the value is only sampled in the load state.
    logic [31:0] rd_port_s1_q, rd_port_s2_q; // Read base port sync
    logic [31:0] wr_port_s1_q, wr_port_s2_q; // Write base port sync

    // Two-stage capture of the run-time base ports
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_port_s1_q <= `ABO_ZERO_BASE;
            rd_port_s2_q <= `ABO_ZERO_BASE;
            wr_port_s1_q <= `ABO_ZERO_BASE;
            wr_port_s2_q <= `ABO_ZERO_BASE;
        end else begin
            rd_port_s1_q <= rd_base_port_in;
            rd_port_s2_q <= rd_port_s1_q;
            wr_port_s1_q <= wr_base_port_in;
            wr_port_s2_q <= wr_port_s1_q;
        end
    end

    // ======================================================
    // Control registers and run state
    // Host writes to the base registers may land at any time; a run
    // only sees them through the copy held in the load state.
    abo_state_e  state_q, state_d;       // Run state
    logic [31:0] base_rd_q, base_rd_d;   // Host read base
    logic [31:0] base_wr_q, base_wr_d;   // Host write base
    logic [31:0] act_rd_q, act_rd_d;     // Held read base for run
    logic [31:0] act_wr_q, act_wr_d;     // Held write base for run
    logic        done_q, done_d;         // Sticky completion flag
    logic        start_q, start_d;       // Datapath start pulse
    logic        start_req;              // Host start write

    assign start_req = reg_wr_in && (reg_addr_in == `ABO_REG_CTRL)
                       && reg_wdata_in[`ABO_CTRL_START];

    // Next-state logic for registers and run sequence
    always_comb begin
        state_d   = state_q;
        base_rd_d = base_rd_q;
        base_wr_d = base_wr_q;
        act_rd_d  = act_rd_q;
        act_wr_d  = act_wr_q;
        done_d    = done_q;
        start_d   = 1'b0;
        // Host writes of base registers in the control slave
        if (reg_wr_in && HAS_CTRL) begin
            if (reg_addr_in == `ABO_REG_BASE_RD) begin
                base_rd_d = reg_wdata_in;
            end else if (reg_addr_in == `ABO_REG_BASE_WR) begin
                base_wr_d = reg_wdata_in;
            end
        end
        // Status read clears done; a set in the same cycle is written
        // later in this process and therefore wins
        if (reg_rd_in && reg_addr_in == `ABO_REG_STATUS) begin
            done_d = 1'b0;
        end
        unique case (state_q)
            ABO_ST_IDLE: begin
                // Start only via a host write of the start bit to ABO_REG_CTRL, also taken when HAS_CTRL is off
                if (start_req) begin
                    state_d = ABO_ST_LOAD;
                end
            end
            ABO_ST_LOAD: begin
                // Queue the base before the datapath moves
                // Fixed masters load their integration base here
                act_rd_d = pick_base(RD_EFF, RD_FIXED_BASE, rd_port_s2_q,
                                     base_rd_q);
                act_wr_d = pick_base(WR_EFF, WR_FIXED_BASE, wr_port_s2_q,
                                     base_wr_q);
                start_d  = 1'b1;
                state_d  = ABO_ST_RUN;
            end
            ABO_ST_RUN: begin
                // Base held until the datapath finishes
                // A start written here is ignored until idle
                if (dp_done_in) begin
                    done_d  = 1'b1;
                    state_d = ABO_ST_IDLE;
                end
            end
            default: begin
                state_d = ABO_ST_IDLE;
            end
        endcase
    end

    // Register stage for control state
    // Before the first start every master runs from byte zero
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q   <= ABO_ST_IDLE;
            base_rd_q <= `ABO_ZERO_BASE;
            base_wr_q <= `ABO_ZERO_BASE;
            act_rd_q  <= `ABO_ZERO_BASE;
            act_wr_q  <= `ABO_ZERO_BASE;
            done_q    <= 1'b0;
            start_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            base_rd_q <= base_rd_d;
            base_wr_q <= base_wr_d;
            act_rd_q  <= act_rd_d;
            act_wr_q  <= act_wr_d;
            done_q    <= done_d;
            start_q   <= start_d;
        end
    end

    // Start pulse and busy come straight from registers
    assign dp_start_out = start_q;
    assign busy_out     = (state_q != ABO_ST_IDLE);

    // ======================================================
    // Read data
    // Read data stand for exactly one cycle and are zero otherwise,
    // so a stale value can never pass for a fresh answer.
    // Unmapped addresses read as zero.
    logic [31:0] rdata_q, rdata_d; // Read data register

    // Decode of register reads
    always_comb begin
        rdata_d = 32'h00000000;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `ABO_REG_STATUS: begin
                    rdata_d[`ABO_STAT_BUSY] = (state_q != ABO_ST_IDLE);
                    rdata_d[`ABO_STAT_DONE] = done_q;
                end
                // Base registers read as zero without a control slave
                `ABO_REG_BASE_RD: begin
                    rdata_d = HAS_CTRL ? base_rd_q : 32'h00000000;
                end
                `ABO_REG_BASE_WR: begin
                    rdata_d = HAS_CTRL ? base_wr_q : 32'h00000000;
                end
                `ABO_REG_ACTIVE_RD: begin
                    rdata_d = act_rd_q;
                end
                `ABO_REG_ACTIVE_WR: begin
                    rdata_d = act_wr_q;
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    // Read data register, valid the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    // ======================================================
    // Address offset path
    // The adder wraps modulo the 32-bit space, so any byte is reachable
    // from any base. Valid is delayed beside the address so both leave
    // on the same edge. Addresses update even when valid is low; the
    // memory side must qualify them with valid.
    logic [31:0] mrd_q, mrd_d;   // Absolute read address
    logic [31:0] mwr_q, mwr_d;   // Absolute write address
    logic        mrdv_q, mrdv_d; // Read address valid
    logic        mwrv_q, mwrv_d; // Write address valid

    // Adds the held base to each datapath address
    always_comb begin
        mrd_d  = add_base(act_rd_q, dp_rd_addr_in);
        mwr_d  = add_base(act_wr_q, dp_wr_addr_in);
        mrdv_d = dp_rd_valid_in;
        mwrv_d = dp_wr_valid_in;
    end

    // Registers the absolute addresses, one cycle of latency
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mrd_q  <= `ABO_ZERO_BASE;
            mwr_q  <= `ABO_ZERO_BASE;
            mrdv_q <= 1'b0;
            mwrv_q <= 1'b0;
        end else begin
            mrd_q  <= mrd_d;
            mwr_q  <= mwr_d;
            mrdv_q <= mrdv_d;
            mwrv_q <= mwrv_d;
        end
    end

    // Outputs taken from flops, free of combinational glitches
    assign mem_rd_addr_out  = mrd_q;
    assign mem_rd_valid_out = mrdv_q;
    assign mem_wr_addr_out  = mwr_q;
    assign mem_wr_valid_out = mwrv_q;

endmodule : abo_base_offset
`default_nettype wire

/* verilog/abo_defs.svh */
// Constants for the memory master base-offset block
// Overview of operation
// - Zero base gives addresses from byte zero
// - Fixed mode uses integration-time base, loaded at the first start; byte zero before it
// - Fixed mode offers no run-time base change
// - Port mode adds 32-bit run-time base input
// - Register mode has host-writable 32-bit base
// - Base added to every read and write
// - Register base queued before reads begin
// - Register mode needs the control slave
// - Each master picks its mode independently
// - Unset mode follows global; slave forces register
// - Base register lives in control slave
`ifndef ABO_DEFS_SVH
`define ABO_DEFS_SVH

// ==========================================================
// Register offsets
`define ABO_REG_CTRL      8'h00
`define ABO_REG_STATUS    8'h04
`define ABO_REG_BASE_RD   8'h08
`define ABO_REG_BASE_WR   8'h0C
`define ABO_REG_ACTIVE_RD 8'h10
`define ABO_REG_ACTIVE_WR 8'h14

// ==========================================================
// Field positions
`define ABO_CTRL_START    0
`define ABO_STAT_BUSY     0
`define ABO_STAT_DONE     1

// ==========================================================
// Reset values
`define ABO_ZERO_BASE     32'h00000000
`define ABO_FIXED_BASE    32'h00000000

`endif

/* verilog/abo_pkg.sv */
// Types for the memory master base-offset block
`default_nettype none
package abo_pkg;
    // Base-address mode of one memory master
    typedef enum logic [1:0] {
        ABO_MODE_FIXED = 2'b00,
        ABO_MODE_PORT  = 2'b01,
        ABO_MODE_REG   = 2'b10,
        ABO_MODE_NONE  = 2'b11
    } abo_mode_e;

    // Run state of the block
    typedef enum logic [1:0] {
        ABO_ST_IDLE = 2'b00,
        ABO_ST_LOAD = 2'b01,
        ABO_ST_RUN  = 2'b10
    } abo_state_e;
endpackage : abo_pkg
`default_nettype wire
